// >>> shared/sync_serial_params.svh
// Offsets, field positions, reset values and timing counts of the serial shift engine.
// Assumes the includer compiles it once per unit; the guard stops double definition.
`ifndef SYNC_SERIAL_PARAMS_SVH
`define SYNC_SERIAL_PARAMS_SVH

// ==========================================================
// Register byte offsets in the memory-mapped config region
`define SSE_OFF_CONTROL 12'hcd0
`define SSE_OFF_TX 12'hcd1
`define SSE_OFF_COMMAND 12'hcd2
`define SSE_OFF_STATUS 12'hcd3
`define SSE_OFF_RX 12'hcd4

// ==========================================================
// Control field positions and reset value
`define SSE_CTL_MSB_FIRST 0
`define SSE_CTL_IDLE_LOW 1
`define SSE_CTL_LATE_PHASE 2
`define SSE_CTL_DONE_IRQ 3
`define SSE_CTL_DIV_LO 4
`define SSE_CTL_DIV_HI 6
`define SSE_CTL_RESET 7'h00

// ==========================================================
// Status field positions
`define SSE_STA_DONE 0
`define SSE_STA_BUSY 1

// ==========================================================
// Timing: edges per byte, smallest half period in system clocks
`define SSE_EDGES 5'h10
`define SSE_HALF_MIN 9'h002
`define SSE_FIFO_DEPTH 16

`endif

// >>> shared/sync_serial_pkg.sv
// Types shared by the serial shift engine.
// Assumes nothing beyond a SystemVerilog compiler.
package sync_serial_pkg;

   typedef enum logic [1:0]
   {
      CMD_NONE,
      CMD_TX,
      CMD_RX,
      CMD_TXRX
   } command_e;

   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_START,
      ST_RUN,
      ST_TAIL,
      ST_GAP
   } engine_e;

   typedef struct packed
   {
      engine_e st;
      logic [6:0] ctl;
      logic [7:0] tx;
      logic [1:0] cmd;
      logic busy;
      logic done;
      logic [7:0] half_cnt;
      logic [4:0] edge_cnt;
      logic [2:0] bit_idx;
      logic [7:0] rx;
      logic sclk;
      logic dout;
      logic push;
      logic [7:0] rdata;
   } engine_s;

endpackage

// >>> verilog/sync_serial_shift_engine.sv
// Byte-wide synchronous serial master with its register port and a receive FIFO.
// Assumes a single system clock; the register port is sampled on that clock and
// the serial peripheral samples and drives on the produced serial clock edges.
`include "sync_serial_params.svh"

// ==========================================================
// Receive FIFO
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)
(
   input wire logic clock_i, // System clock
   input wire logic rst_n_i, // Synchronised reset, active low
   input wire logic in_valid_i, // Producer has a word
   output logic in_ready_o, // Room for a word
   input wire logic [WIDTH-1:0] in_data_i, // Word to store
   output logic out_valid_o, // A word is waiting
   input wire logic out_ready_i, // Consumer takes the word
   output logic [WIDTH-1:0] out_data_o // Oldest word
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wr;
      logic [AW:0] rd;
   } fifo_s;

   fifo_s s_reg;
   fifo_s s_next;
   logic full;
   logic empty;

   assign empty = s_reg.wr == s_reg.rd;
   assign full = (s_reg.wr[AW] != s_reg.rd[AW]) && (s_reg.wr[AW-1:0] == s_reg.rd[AW-1:0]);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = s_reg.mem[s_reg.rd[AW-1:0]];

   always_comb
   begin
      s_next = s_reg;
      if (in_valid_i && !full)
      begin
         s_next.mem[s_reg.wr[AW-1:0]] = in_data_i;
         s_next.wr = s_reg.wr + 1'b1;
      end
      if (out_ready_i && !empty)
      begin
         s_next.rd = s_reg.rd + 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end
endmodule // byte_fifo

// ==========================================================
// Serial shift engine
module sync_serial_shift_engine
   import sync_serial_pkg::*;
(
   input wire logic clock_i, // System clock, 20 MHz
   input wire logic rst_n_i, // Asynchronous reset, active low
   input wire logic [11:0] reg_addr_i, // Register byte offset
   input wire logic reg_wr_i, // Register write strobe
   input wire logic [7:0] reg_wdata_i, // Write data
   input wire logic reg_rd_i, // Register read strobe
   output logic [7:0] reg_rdata_o, // Read data, one clock after strobe
   output logic serial_clock_out_o, // Serial clock pin
   output logic serial_data_out_o, // Serial data pin toward peripheral
   input wire logic serial_data_in_i, // Serial data pin from peripheral
   output logic done_irq_o // Completion interrupt request, level
);
   engine_s s_reg;
   engine_s s_next;
   logic rst_n;
   logic [1:0] rst_sync_reg;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic rx_pop;
   logic wr_ctl;
   logic wr_tx;
   logic wr_cmd;
   logic wr_sta;
   logic idle_low;
   logic late;
   logic wants_rx;
   logic tx_bit;

   // Reset is released through two flops; asserting stays asynchronous
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_sync_reg <= 2'h0;
      end
      else
      begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   assign wr_ctl = reg_wr_i && (reg_addr_i == `SSE_OFF_CONTROL);
   assign wr_tx = reg_wr_i && (reg_addr_i == `SSE_OFF_TX);
   assign wr_cmd = reg_wr_i && (reg_addr_i == `SSE_OFF_COMMAND);
   assign wr_sta = reg_wr_i && (reg_addr_i == `SSE_OFF_STATUS);
   assign rx_pop = reg_rd_i && (reg_addr_i == `SSE_OFF_RX);
   assign idle_low = s_reg.ctl[`SSE_CTL_IDLE_LOW];
   assign late = s_reg.ctl[`SSE_CTL_LATE_PHASE];
   assign wants_rx = s_reg.cmd[1];
   // Bit order picks which transmit bit goes next
   assign tx_bit = s_reg.ctl[`SSE_CTL_MSB_FIRST] ? s_reg.tx[3'h7 - s_reg.bit_idx]
                                                 : s_reg.tx[s_reg.bit_idx];

   // Receive bytes queue here; a full queue holds off the next receive
   byte_fifo #(
      .WIDTH(8),
      .DEPTH(`SSE_FIFO_DEPTH)
   ) rx_fifo (
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .in_valid_i(s_reg.push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(s_reg.rx),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(rx_pop),
      .out_data_o(fifo_out_data)
   );

   always_comb
   begin
      s_next = s_reg;
      s_next.push = 1'b0;
      s_next.rdata = 8'h00;
      // ==========================================================
      // Register reads
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            `SSE_OFF_CONTROL: s_next.rdata = {1'b0, s_reg.ctl};
            `SSE_OFF_TX: s_next.rdata = s_reg.tx;
            `SSE_OFF_COMMAND: s_next.rdata = {6'h00, s_reg.cmd};
            `SSE_OFF_STATUS: s_next.rdata = {6'h00, s_reg.busy, s_reg.done};
            `SSE_OFF_RX: s_next.rdata = fifo_out_valid ? fifo_out_data : 8'h00;
            default: s_next.rdata = 8'h00;
         endcase
      end
      // ==========================================================
      // Register writes; bit 7 of control is not stored
      if (wr_ctl)
      begin
         s_next.ctl = reg_wdata_i[6:0];
      end
      if (wr_tx)
      begin
         s_next.tx = reg_wdata_i;
      end
      if (wr_sta && reg_wdata_i[`SSE_STA_DONE])
      begin
         s_next.done = 1'b0;
      end
      // ==========================================================
      // Shift engine
      unique case (s_reg.st)
         ST_IDLE:
         begin
            // Idle level follows the idle-low bit only
            s_next.sclk = !idle_low;
            if (wr_cmd)
            begin
               s_next.cmd = reg_wdata_i[1:0];
               if (reg_wdata_i[1:0] != CMD_NONE)
               begin
                  s_next.busy = 1'b1;
                  s_next.st = ST_START;
               end
            end
         end
         ST_START:
         begin
            // Receive waits for queue room so no byte is dropped
            if (!wants_rx || fifo_in_ready)
            begin
               s_next.half_cnt = 8'((`SSE_HALF_MIN << s_reg.ctl[6:4]) - 9'h001);
               s_next.edge_cnt = 5'h00;
               s_next.bit_idx = 3'h0;
               s_next.rx = 8'h00;
               if (late && s_reg.cmd[0])
               begin
                  s_next.dout = tx_bit;
                  s_next.bit_idx = 3'h1;
               end
               s_next.st = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (s_reg.half_cnt != 8'h00)
            begin
               s_next.half_cnt = s_reg.half_cnt - 8'h01;
            end
            else
            begin
               s_next.half_cnt = 8'((`SSE_HALF_MIN << s_reg.ctl[6:4]) - 9'h001);
               s_next.sclk = !s_reg.sclk;
               s_next.edge_cnt = s_reg.edge_cnt + 5'h01;
               // edge_cnt even means this is an odd-numbered edge
               if (late == s_reg.edge_cnt[0])
               begin
                  // Drive edge: odd in normal phase, even in late
                  if (s_reg.cmd[0] && s_reg.edge_cnt != 5'h0f)
                  begin
                     s_next.dout = tx_bit;
                     s_next.bit_idx = s_reg.bit_idx + 3'h1;
                  end
               end
               else if (wants_rx)
               begin
                  // Sample edge: even normal, odd late
                  s_next.rx = s_reg.ctl[`SSE_CTL_MSB_FIRST] ? {s_reg.rx[6:0], serial_data_in_i}
                                                            : {serial_data_in_i, s_reg.rx[7:1]};
               end
               if (s_reg.edge_cnt == `SSE_EDGES - 5'h01)
               begin
                  s_next.st = late ? ST_GAP : ST_TAIL;
               end
            end
         end
         ST_TAIL:
         begin
            // Normal phase ends half a period after the final edge
            if (s_reg.half_cnt != 8'h00)
            begin
               s_next.half_cnt = s_reg.half_cnt - 8'h01;
            end
            else
            begin
               s_next.st = ST_GAP;
            end
         end
         ST_GAP:
         begin
            // Completion, then one idle clock before the next command
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
            s_next.push = wants_rx;
            s_next.st = ST_IDLE;
         end
         default:
         begin
            s_next.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg.st <= ST_IDLE;
         s_reg.ctl <= `SSE_CTL_RESET;
         s_reg.tx <= 8'h00;
         s_reg.cmd <= 2'h0;
         s_reg.busy <= 1'b0;
         s_reg.done <= 1'b0;
         s_reg.half_cnt <= 8'h00;
         s_reg.edge_cnt <= 5'h00;
         s_reg.bit_idx <= 3'h0;
         s_reg.rx <= 8'h00;
         s_reg.sclk <= 1'b1;
         s_reg.dout <= 1'b0;
         s_reg.push <= 1'b0;
         s_reg.rdata <= 8'h00;
      end
      else
      begin
         s_reg.st <= s_next.st;
         s_reg.ctl <= s_next.ctl;
         s_reg.tx <= s_next.tx;
         s_reg.cmd <= s_next.cmd;
         s_reg.busy <= s_next.busy;
         s_reg.done <= s_next.done;
         s_reg.half_cnt <= s_next.half_cnt;
         s_reg.edge_cnt <= s_next.edge_cnt;
         s_reg.bit_idx <= s_next.bit_idx;
         s_reg.rx <= s_next.rx;
         s_reg.sclk <= s_next.sclk;
         s_reg.dout <= s_next.dout;
         s_reg.push <= s_next.push;
         s_reg.rdata <= s_next.rdata;
      end
   end

   assign reg_rdata_o = s_reg.rdata;
   assign serial_clock_out_o = s_reg.sclk;
   assign serial_data_out_o = s_reg.dout;
   assign done_irq_o = s_reg.done && s_reg.ctl[`SSE_CTL_DONE_IRQ];
endmodule // sync_serial_shift_engine

// >>> verification/sync_serial_shift_engine_assertions.sv
// Port-level checks of the serial shift engine.
// Assumes one clock; control writes land one clock after their strobe.
`include "sync_serial_params.svh"
module sse_checker (
   input wire logic clock_i, // System clock
   input wire logic rst_n_i, // Reset, active low
   input wire logic [11:0] reg_addr_i, // Register offset
   input wire logic reg_wr_i, // Write strobe
   input wire logic [7:0] reg_wdata_i, // Write data
   input wire logic reg_rd_i, // Read strobe
   input wire logic [7:0] reg_rdata_o, // Read data
   input wire logic serial_clock_out_o, // Serial clock
   input wire logic serial_data_out_o, // Serial data out
   input wire logic serial_data_in_i, // Serial data in
   input wire logic done_irq_o // Completion request
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Shadow of control and serial clock edge tracking
   logic [6:0] ctl_q;
   logic [2:0] ctl_age;
   logic sclk_q;
   logic [3:0] edge_n;
   logic [9:0] gap;
   logic toggle;
   logic [9:0] half;
   // Idle level moves after a control write are not serial clock edges
   assign toggle = serial_clock_out_o != sclk_q && ctl_age == 3'h4;
   assign half = 10'h002 << ctl_q[6:4];
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ctl_q <= 7'h00;
         ctl_age <= 3'h0;
         sclk_q <= 1'b1;
         edge_n <= 4'h0;
         gap <= 10'h000;
      end
      else
      begin
         sclk_q <= serial_clock_out_o;
         ctl_q <= (reg_wr_i && reg_addr_i == `SSE_OFF_CONTROL) ? reg_wdata_i[6:0] : ctl_q;
         ctl_age <= (reg_wr_i && reg_addr_i == `SSE_OFF_CONTROL) ? 3'h0 :
            (ctl_age == 3'h4 ? ctl_age : ctl_age + 3'h1);
         gap <= toggle ? 10'h001 : gap + 10'h001;
         edge_n <= toggle ? edge_n + 4'h1 : edge_n;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   a_ctl_read_back:
      assert property (reg_rd_i && reg_addr_i == `SSE_OFF_CONTROL |=> reg_rdata_o == {1'b0, ctl_q})
      else $error("Control read back wrong");
   a_status_rsv_zero:
      assert property (reg_rd_i && reg_addr_i == `SSE_OFF_STATUS |=> reg_rdata_o[7:2] == 6'h00)
      else $error("Status upper bits set");
   a_irq_masked:
      assert property (!ctl_q[3] |-> !done_irq_o)
      else $error("Request while disabled");
   a_irq_held:
      assert property (done_irq_o && !(reg_wr_i && (reg_addr_i == `SSE_OFF_CONTROL ||
         (reg_addr_i == `SSE_OFF_STATUS && reg_wdata_i[0]))) |=> done_irq_o)
      else $error("Request dropped without clear");
   a_half_period:
      assert property (toggle && edge_n != 4'h0 |-> gap == half)
      else $error("Half period wrong");
   a_idle_level:
      assert property (edge_n == 4'h0 && !toggle && ctl_age == 3'h4 |->
         serial_clock_out_o == !ctl_q[1])
      else $error("Serial clock idle level wrong");
   a_done_in_gap:
      assert property ($rose(done_irq_o) && $stable(ctl_q) |-> edge_n == 4'h0)
      else $error("Completion inside a frame");
   a_done_prompt:
      assert property (toggle && edge_n == 4'hf && ctl_q[3] |-> ##[1:300] done_irq_o)
      else $error("No completion after last edge");
   a_dout_phase:
      assert property ($changed(serial_data_out_o) |->
         (toggle && edge_n[0] == ctl_q[2]) || (ctl_q[2] && edge_n == 4'h0))
      else $error("Data out moved on wrong edge");
   a_frame_gap:
      assert property (toggle && edge_n == 4'hf |=> !toggle [*3])
      else $error("Next frame started without idle clocks");
   c_late_frame: cover property (toggle && edge_n == 4'hf && ctl_q[2]);
   c_irq_rise: cover property ($rose(done_irq_o));
   c_slow_clock: cover property (toggle && ctl_q[6:4] == 3'h7);
endmodule // sse_checker

bind sync_serial_shift_engine sse_checker u_sse_checker (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .serial_clock_out_o(serial_clock_out_o),
   .serial_data_out_o(serial_data_out_o), .serial_data_in_i(serial_data_in_i),
   .done_irq_o(done_irq_o));

// >>> verification/sync_serial_peripheral_model.sv
// Serial peripheral on the far side of the link.
// Assumes the bench selects it around each frame and tells it the link mode.
module sync_serial_peripheral_model (
   input wire logic serial_clock_i, // Serial clock
   input wire logic serial_data_i, // Data from engine
   output logic serial_data_o, // Data to engine
   input wire logic sel_i, // Selected
   input wire logic late_phase_i, // Phase mode
   input wire logic msb_first_i, // Bit order
   input wire logic [7:0] tx_byte_i, // Byte to send
   output logic [7:0] rx_byte_o // Byte received
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = 0;
   initial serial_data_o = 1'b0;
   function automatic int pos(input int k);
      return msb_first_i ? 7 - k : k;
   endfunction
   always @(posedge sel_i)
   begin
      n = 0;
      if (late_phase_i)
         serial_data_o = tx_byte_i[pos(0)];
   end
   // No pull on the line, so a released pin shows the opposite of its last bit
   always @(negedge sel_i) serial_data_o = ~serial_data_o;
   always @(serial_clock_i)
   begin
      if (sel_i)
      begin
         n++;
         if (n[0] ^ late_phase_i)
         begin
            if (n < 16)
               serial_data_o = tx_byte_i[pos(n >> 1)];
         end
         else
            rx_byte_o[pos((n - 1) >> 1)] = serial_data_i;
      end
   end
endmodule // sync_serial_peripheral_model

// >>> verification/sync_serial_shift_engine_tb.sv
// Self-checking bench: register port driven by tasks, peripheral model on the link.
// Assumes the engine, its FIFO, checker and peripheral model are compiled first.
`include "sync_serial_params.svh"
module sync_serial_shift_engine_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i = '0, rst_n_i = '0, reg_wr_i = '0, reg_rd_i = '0, sel = '0, sclk_q = '1;
   logic [11:0] reg_addr_i = '0;
   logic [7:0] reg_wdata_i = '0, reg_rdata_o, rd, ctl = '0, tx, pb, got;
   logic serial_clock_out_o, serial_data_out_o, serial_data_in_i, done_irq_o;
   logic [9:0] gap = '0, last_gap = '0, toggles = '0, base = '0;
   int fails = 0, n_checks = 0;
   always #25 clock_i = ~clock_i;
   sync_serial_shift_engine u_sync_serial_shift_engine (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .serial_clock_out_o(serial_clock_out_o),
      .serial_data_out_o(serial_data_out_o), .serial_data_in_i(serial_data_in_i),
      .done_irq_o(done_irq_o));
   sync_serial_peripheral_model u_sync_serial_peripheral_model (
      .serial_clock_i(serial_clock_out_o), .serial_data_i(serial_data_out_o),
      .serial_data_o(serial_data_in_i), .sel_i(sel), .late_phase_i(ctl[2]),
      .msb_first_i(ctl[0]), .tx_byte_i(pb), .rx_byte_o(got));
   // ==========================================================
   // Serial clock edge counter and spacing
   always @(posedge clock_i)
   begin
      if (serial_clock_out_o !== sclk_q)
      begin
         last_gap = gap;
         gap = 10'h001;
         toggles = toggles + 10'h001;
      end
      else
         gap = gap + 10'h001;
      sclk_q = serial_clock_out_o;
   end
   // ==========================================================
   // Tasks
   task automatic chk(input logic [9:0] g, input logic [9:0] e);
      n_checks++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock_i);
      #1 reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(posedge clock_i);
      #1 reg_wr_i = 1'b0;
   endtask
   task automatic rd_reg(input logic [11:0] a);
      @(posedge clock_i);
      #1 reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(posedge clock_i);
      #1 reg_rd_i = 1'b0;
      rd = reg_rdata_o;
   endtask
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic xfer(input logic [6:0] c, input logic [1:0] cmd);
      int k;
      ctl = {1'b0, c};
      tx = 8'($urandom);
      pb = 8'($urandom);
      wr(`SSE_OFF_CONTROL, ctl);
      wr(`SSE_OFF_TX, tx);
      sel = 1'b1;
      repeat (4) @(posedge clock_i);
      #1 base = toggles;
      wr(`SSE_OFF_COMMAND, {6'h00, cmd});
      for (k = 0; k < 3000; k++)
      begin
         rd_reg(`SSE_OFF_STATUS);
         if (rd[1] === 1'b0)
            break;
      end
      sel = 1'b0;
      chk(toggles - base, 10'h010);
      chk(last_gap, 10'h002 << c[6:4]);
      chk(10'(serial_clock_out_o), 10'(!c[1]));
      if (cmd[0])
         chk(10'(got), 10'(tx));
      chk(10'(rd), 10'h001);
      chk(10'(done_irq_o), 10'(c[3]));
      wr(`SSE_OFF_STATUS, 8'h02);
      rd_reg(`SSE_OFF_STATUS);
      chk(10'(rd), 10'h001);
      wr(`SSE_OFF_STATUS, 8'h01);
      rd_reg(`SSE_OFF_STATUS);
      chk(10'(rd), 10'h000);
      rd_reg(`SSE_OFF_RX);
      chk(10'(rd), cmd[1] ? 10'(pb) : 10'h000);
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial
   begin
      void'($urandom(23));
      repeat (20) @(posedge clock_i);
      #1 rst_n_i = 1'b1;
      repeat (3) @(posedge clock_i);
      rd_reg(`SSE_OFF_CONTROL);
      chk(10'(rd), 10'h000);
      chk(10'(serial_clock_out_o), 10'h001);
      wr(`SSE_OFF_CONTROL, 8'hff);
      rd_reg(`SSE_OFF_CONTROL);
      chk(10'(rd), 10'h07f);
      wr(`SSE_OFF_COMMAND, 8'h00);
      rd_reg(`SSE_OFF_STATUS);
      chk(10'(rd), 10'h000);
      rd_reg(12'hcd8);
      chk(10'(rd), 10'h000);
      for (int i = 0; i < 16; i++)
         xfer({i[2:0], 4'($urandom)}, 2'(i % 3 + 1));
      stop_test();
   end
   // Budget covers two sweeps of every divisor with margin
   initial
   begin
      #(60000 * 50);
      fails++;
      stop_test();
   end
endmodule // sync_serial_shift_engine_tb
